// ==== hw/mcs_regs.vh ====
`ifndef MCS_REGS_VH
`define MCS_REGS_VH

// Machine cycle kinds
`define MCS_K_ALU 3'h0
`define MCS_K_MRD 3'h1
`define MCS_K_MWR 3'h2
`define MCS_K_SIN 3'h3
`define MCS_K_SOUT 3'h4

// Addressing modes of a source or destination field
`define MCS_M_REG 2'h0
`define MCS_M_IND 2'h1
`define MCS_M_SYM 2'h2
`define MCS_M_INC 2'h3

// Derivation lengths in machine cycles
`define MCS_N_REG 2'h0
`define MCS_N_IND 2'h2
`define MCS_N_INC 2'h3
`define MCS_N_SYM 2'h3

// Address modification cost, clocks and memory cycles
`define MCS_IND_CLK 8'h04
`define MCS_IND_MEM 4'h1
`define MCS_INC_CLK 8'h06
`define MCS_INC_MEM 4'h2
`define MCS_SYM_CLK 8'h06
`define MCS_SYM_MEM 4'h1
`define MCS_IDX_MEM 4'h2

// Fixed instruction costs
`define MCS_TRAP_CLK 8'h18
`define MCS_TRAP_MEM 4'h6
`define MCS_X_CLK 8'h04
`define MCS_X_MEM 4'h1
`define MCS_SH_CLK 8'h0c
`define MCS_SH_MEM 4'h3
`define MCS_SHW_CLK 8'h14
`define MCS_SHZ_CLK 8'h34
`define MCS_SHW_MEM 4'h4

`endif

// ==== hw/mcs_cost.v ====
`timescale 1ns/10ps
`default_nettype none
`include "mcs_regs.vh"

module mcs_cost (
	// Decoded instruction
	input wire [15:0] opcode_i,
	input wire [7:0] base_clk_i,
	input wire [3:0] base_mem_i,
	input wire [1:0] ts_i,
	input wire s_reg_zero_i,
	input wire [1:0] td_i,
	input wire d_reg_zero_i,
	input wire use_dst_i,
	input wire [3:0] workspace_reg_zero_i,
	input wire ext_instr_present_i,
	// Cost
	output reg [7:0] clk_o,
	output reg [3:0] mem_o,
	output reg trap_o,
	output reg ext_o
);

	// -------------------------------
	// Address modification cost
	// -------------------------------
	function [11:0] mod_cost;
		input [1:0] m;
		input z;
		begin
			case (m)
				`MCS_M_IND: mod_cost = {`MCS_IND_CLK, `MCS_IND_MEM};
				`MCS_M_INC: mod_cost = {`MCS_INC_CLK, `MCS_INC_MEM};
				`MCS_M_SYM: mod_cost = {`MCS_SYM_CLK, z ? `MCS_SYM_MEM : `MCS_IDX_MEM};
				default: mod_cost = 12'h000;
			endcase
		end
	endfunction

	wire [11:0] src_c = mod_cost(ts_i, s_reg_zero_i);
	wire [11:0] dst_c = use_dst_i ? mod_cost(td_i, d_reg_zero_i) : 12'h000;
	wire [3:0] sh_cnt = opcode_i[7:4];
	wire is_shift = (opcode_i[15:10] == 6'h02);
	wire is_x = (opcode_i[15:6] == 10'h012);
	// Undefined opcode ranges
	wire undef = (opcode_i < 16'h0080) ||
		(opcode_i >= 16'h00a0 && opcode_i < 16'h0180) ||
		(opcode_i >= 16'h0320 && opcode_i < 16'h0340) ||
		(opcode_i >= 16'h0780 && opcode_i < 16'h0800) ||
		(opcode_i >= 16'h0c00 && opcode_i < 16'h1000);

	// Cost selection
	always @* begin
		trap_o = 1'b0;
		ext_o = 1'b0;
		clk_o = 8'h00;
		mem_o = 4'h0;
		if (undef) begin
			trap_o = ~ext_instr_present_i;
			ext_o = ext_instr_present_i;
			if (!ext_instr_present_i) begin
				clk_o = `MCS_TRAP_CLK;
				mem_o = `MCS_TRAP_MEM;
			end
		end else if (is_shift) begin
			if (sh_cnt != 4'h0) begin
				clk_o = `MCS_SH_CLK + {3'h0, sh_cnt, 1'b0};
				mem_o = `MCS_SH_MEM;
			end else if (workspace_reg_zero_i == 4'h0) begin
				clk_o = `MCS_SHZ_CLK;
				mem_o = `MCS_SHW_MEM;
			end else begin
				clk_o = `MCS_SHW_CLK + {3'h0, workspace_reg_zero_i, 1'b0};
				mem_o = `MCS_SHW_MEM;
			end
		end else if (is_x) begin
			clk_o = `MCS_X_CLK + src_c[11:4];
			mem_o = `MCS_X_MEM + src_c[3:0];
		end else begin
			clk_o = base_clk_i + src_c[11:4] + dst_c[11:4];
			mem_o = base_mem_i + src_c[3:0] + dst_c[3:0];
		end
	end

endmodule

`default_nettype wire

// ==== hw/mcs_sequencer.v ====
// Summary of operation
// - Only ALU, memory and serial cycles exist
// - ALU cycle: two clocks, controls untouched
// - Memory cycle drives memory bus controls
// - Memory cycle lasts two plus waits
// - Serial cycle moves one bit, two clocks plus waits
// - Bit address and output bit in clock one
// - Serial input sampled in last two clocks
// - Output strobe pulsed in second clock
// - Ready sampled at second clock start
// - Derivation phase then execution phase
// - Register mode adds no cycles
// - Auto-increment: read, ALU, write inserted
// - Shift count zero uses register zero
// - Undefined opcodes trap when no extension
// - Execute adds four clocks, one memory
`timescale 1ns/10ps
`default_nettype none
`include "mcs_regs.vh"

module mcs_sequencer #(
	parameter AW = 16,
	parameter DW = 16
) (
	// Clock and reset
	input wire clk_i,
	input wire resetn_i,
	// Instruction start and operand modes
	input wire instr_start_i,
	input wire instr_end_i,
	input wire [15:0] opcode_i,
	input wire [7:0] base_clk_i,
	input wire [3:0] base_mem_i,
	input wire [1:0] ts_i,
	input wire s_reg_zero_i,
	input wire [1:0] td_i,
	input wire d_reg_zero_i,
	input wire use_dst_i,
	input wire [3:0] workspace_reg_zero_i,
	// Machine cycle requests
	input wire mc_req_i,
	input wire [2:0] mc_kind_i,
	input wire [AW-1:0] mc_addr_i,
	input wire [DW-1:0] mc_wdata_i,
	// Pins from outside
	input wire ready_i,
	input wire serial_io_input_i,
	input wire ext_instr_present_i,
	input wire [DW-1:0] mem_rdata_i,
	// Memory bus
	output reg [AW-1:0] mem_addr_o,
	output reg [DW-1:0] mem_wdata_o,
	output reg mem_en_o,
	output reg mem_we_o,
	output reg [DW-1:0] rdata_o,
	// Serial bit bus
	output reg [AW-1:0] bit_addr_o,
	output reg serial_io_output_o,
	output reg serial_io_strobe_o,
	output reg serial_io_bit_o,
	output reg bit_valid_o,
	// Sequencer status
	output reg mc_take_o,
	output reg mc_done_o,
	output reg [3:0] phase_o,
	output reg [7:0] cost_clk_o,
	output reg [3:0] cost_mem_o,
	output reg trap_o,
	output reg ext_exec_o
);

	// -------------------------------
	// States
	// -------------------------------
	localparam E_IDLE = 4'h1;
	localparam E_C1 = 4'h2;
	localparam E_C2 = 4'h4;
	localparam E_WT = 4'h8;
	localparam P_IDLE = 4'h1;
	localparam P_SRC = 4'h2;
	localparam P_DST = 4'h4;
	localparam P_EXEC = 4'h8;

	// -------------------------------
	// Pin synchronisers
	// -------------------------------
	reg [2:0] s1_q, s2_q, s3_q, pin_q;
	wire [2:0] pin_raw = {ext_instr_present_i, serial_io_input_i, ready_i};

	// Three stages, a change counts once stages two and three agree
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			s3_q <= 3'h0;
			pin_q <= 3'h0;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
		end
	end

	wire rdy = pin_q[0];
	wire sin_bit = pin_q[1];
	wire ext_p = pin_q[2];

	// -------------------------------
	// Instruction cost
	// -------------------------------
	wire [7:0] c_clk;
	wire [3:0] c_mem;
	wire c_trap, c_ext;

	mcs_cost u_cost (
		.opcode_i(opcode_i),
		.base_clk_i(base_clk_i),
		.base_mem_i(base_mem_i),
		.ts_i(ts_i),
		.s_reg_zero_i(s_reg_zero_i),
		.td_i(td_i),
		.d_reg_zero_i(d_reg_zero_i),
		.use_dst_i(use_dst_i),
		.workspace_reg_zero_i(workspace_reg_zero_i),
		.ext_instr_present_i(ext_p),
		.clk_o(c_clk),
		.mem_o(c_mem),
		.trap_o(c_trap),
		.ext_o(c_ext)
	);

	// -------------------------------
	// Derivation tables
	// -------------------------------
	function [1:0] deriv_len;
		input [1:0] m;
		begin
			case (m)
				`MCS_M_IND: deriv_len = `MCS_N_IND;
				`MCS_M_INC: deriv_len = `MCS_N_INC;
				`MCS_M_SYM: deriv_len = `MCS_N_SYM;
				default: deriv_len = `MCS_N_REG;
			endcase
		end
	endfunction

	function [2:0] deriv_kind;
		input [1:0] m;
		input z;
		input [1:0] step;
		begin
			case (m)
				`MCS_M_IND: deriv_kind = (step == 2'h0) ? `MCS_K_MRD : `MCS_K_ALU;
				`MCS_M_INC: deriv_kind = (step == 2'h0) ? `MCS_K_MRD :
					(step == 2'h1) ? `MCS_K_ALU : `MCS_K_MWR;
				`MCS_M_SYM: deriv_kind = z ? ((step == 2'h1) ? `MCS_K_MRD : `MCS_K_ALU) :
					((step == 2'h2) ? `MCS_K_ALU : `MCS_K_MRD);
				default: deriv_kind = `MCS_K_ALU;
			endcase
		end
	endfunction

	// -------------------------------
	// Registers
	// -------------------------------
	reg [3:0] eng_q, eng_d;
	reg [3:0] ph_q, ph_d;
	reg [2:0] kind_q;
	reg [1:0] step_q, step_d;
	reg [1:0] ts_q, td_q;
	reg sz_q, dz_q, dst_q;
	reg [2:0] sin_pend_q;

	// Current derivation field
	wire in_src = (ph_q == P_SRC);
	wire [1:0] cur_m = in_src ? ts_q : td_q;
	wire cur_z = in_src ? sz_q : dz_q;
	wire [1:0] cur_n = deriv_len(cur_m);
	wire deriv_want = (in_src || ph_q == P_DST) && (step_q < cur_n);
	wire [2:0] d_kind = deriv_kind(cur_m, cur_z, step_q);

	// Engine finishes its current machine cycle this clock
	wire k_alu = (kind_q == `MCS_K_ALU);
	wire fin = ((eng_q == E_C2) && (k_alu || rdy)) || ((eng_q == E_WT) && rdy);
	wire eng_free = (eng_q == E_IDLE) || fin;
	wire ext_ok = mc_req_i && (ph_q == P_IDLE || ph_q == P_EXEC);
	wire go = eng_free && (deriv_want || ext_ok);
	wire [2:0] go_kind = deriv_want ? d_kind : mc_kind_i;

	// -------------------------------
	// Engine next state
	// -------------------------------
	always @* begin
		case (eng_q)
			E_IDLE: eng_d = go ? E_C1 : E_IDLE;
			E_C1: eng_d = E_C2;
			E_C2: eng_d = go ? E_C1 : (fin ? E_IDLE : E_WT);
			E_WT: eng_d = go ? E_C1 : (fin ? E_IDLE : E_WT);
			default: eng_d = E_IDLE;
		endcase
	end

	// -------------------------------
	// Phase next state
	// -------------------------------
	always @* begin
		ph_d = ph_q;
		step_d = step_q;
		case (ph_q)
			P_IDLE: begin
				if (instr_start_i && !go) begin
					ph_d = P_SRC;
					step_d = 2'h0;
				end
			end
			P_SRC: begin
				if (deriv_want) begin
					if (go) begin
						step_d = step_q + 2'h1;
					end
				end else begin
					ph_d = dst_q ? P_DST : P_EXEC;
					step_d = 2'h0;
				end
			end
			P_DST: begin
				if (deriv_want) begin
					if (go) begin
						step_d = step_q + 2'h1;
					end
				end else begin
					ph_d = P_EXEC;
				end
			end
			P_EXEC: begin
				if (instr_end_i) begin
					ph_d = P_IDLE;
				end
			end
			default: ph_d = P_IDLE;
		endcase
	end

	// -------------------------------
	// State and capture registers
	// -------------------------------
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			eng_q <= E_IDLE;
			ph_q <= P_IDLE;
			step_q <= 2'h0;
			kind_q <= `MCS_K_ALU;
			ts_q <= 2'h0;
			td_q <= 2'h0;
			sz_q <= 1'b0;
			dz_q <= 1'b0;
			dst_q <= 1'b0;
			cost_clk_o <= 8'h00;
			cost_mem_o <= 4'h0;
			trap_o <= 1'b0;
			ext_exec_o <= 1'b0;
			phase_o <= P_IDLE;
		end else begin
			eng_q <= eng_d;
			ph_q <= ph_d;
			step_q <= step_d;
			phase_o <= ph_d;
			if (go) begin
				kind_q <= go_kind;
			end
			// Operand modes and cost taken at instruction start
			if (ph_q == P_IDLE && ph_d == P_SRC) begin
				ts_q <= ts_i;
				td_q <= td_i;
				sz_q <= s_reg_zero_i;
				dz_q <= d_reg_zero_i;
				dst_q <= use_dst_i;
				cost_clk_o <= c_clk;
				cost_mem_o <= c_mem;
				trap_o <= c_trap;
				ext_exec_o <= c_ext;
			end
		end
	end

	// -------------------------------
	// Memory bus outputs
	// -------------------------------
	wire go_mem = go && (go_kind == `MCS_K_MRD || go_kind == `MCS_K_MWR);

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			mem_addr_o <= {AW{1'b0}};
			mem_wdata_o <= {DW{1'b0}};
			mem_en_o <= 1'b0;
			mem_we_o <= 1'b0;
			rdata_o <= {DW{1'b0}};
		end else begin
			if (go_mem) begin
				mem_addr_o <= mc_addr_i;
				mem_wdata_o <= mc_wdata_i;
				mem_en_o <= 1'b1;
				mem_we_o <= (go_kind == `MCS_K_MWR);
			end else if (fin && (kind_q == `MCS_K_MRD || kind_q == `MCS_K_MWR)) begin
				mem_en_o <= 1'b0;
				mem_we_o <= 1'b0;
			end
			// Read data taken on the finishing edge
			if (fin && kind_q == `MCS_K_MRD) begin
				rdata_o <= mem_rdata_i;
			end
		end
	end

	// -------------------------------
	// Serial bit outputs
	// -------------------------------
	wire go_ser = go && (go_kind == `MCS_K_SIN || go_kind == `MCS_K_SOUT);

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			bit_addr_o <= {AW{1'b0}};
			serial_io_output_o <= 1'b0;
			serial_io_strobe_o <= 1'b0;
			serial_io_bit_o <= 1'b0;
			bit_valid_o <= 1'b0;
			sin_pend_q <= 3'h0;
		end else begin
			if (go_ser) begin
				bit_addr_o <= mc_addr_i;
				if (go_kind == `MCS_K_SOUT) begin
					serial_io_output_o <= mc_wdata_i[0];
				end
			end
			// One strobe pulse in the second clock
			serial_io_strobe_o <= (eng_q == E_C1) && (kind_q == `MCS_K_SOUT);
			// Wait out the pin filter so the bit taken stood in the cycle's last two clocks
			sin_pend_q <= {sin_pend_q[1:0], fin && (kind_q == `MCS_K_SIN)};
			bit_valid_o <= sin_pend_q[2];
			if (sin_pend_q[2]) begin
				serial_io_bit_o <= sin_bit;
			end
		end
	end

	// -------------------------------
	// Handshake pulses
	// -------------------------------
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			mc_take_o <= 1'b0;
			mc_done_o <= 1'b0;
		end else begin
			mc_take_o <= go && !deriv_want;
			mc_done_o <= fin;
		end
	end

endmodule

`default_nettype wire

// ==== bench/mcs_seq_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// Machine cycle timing checker
// ----------------------------
module mcs_seq_checker #(
	parameter AW = 16,
	parameter DW = 16
) (
	// Clock and requests
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [2:0] mc_kind_i,
	input wire logic [AW-1:0] mc_addr_i,
	input wire logic [DW-1:0] mc_wdata_i,
	// Bus outputs
	input wire logic [AW-1:0] mem_addr_o,
	input wire logic mem_en_o,
	input wire logic mem_we_o,
	input wire logic [AW-1:0] bit_addr_o,
	input wire logic serial_io_output_o,
	input wire logic serial_io_strobe_o,
	input wire logic bit_valid_o,
	input wire logic mc_take_o,
	input wire logic mc_done_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	// Kind of the cycle just taken
	wire logic tk_alu = mc_take_o && mc_kind_i == 3'h0;
	wire logic tk_mem = mc_take_o && (mc_kind_i == 3'h1 || mc_kind_i == 3'h2);
	wire logic tk_out = mc_take_o && mc_kind_i == 3'h4;
	wire logic tk_sio = tk_out || (mc_take_o && mc_kind_i == 3'h3);

	a_alu_two: assert property (tk_alu |=> !mc_done_o ##1 mc_done_o)
		else $error("alu cycle length wrong");
	a_alu_quiet: assert property (tk_alu |=> ($stable(mem_addr_o) &&
		$stable(mem_en_o) && $stable(bit_addr_o)) [*2])
		else $error("alu cycle moved bus");
	a_mem_ctl: assert property (tk_mem |-> mem_en_o && mem_addr_o == mc_addr_i &&
		mem_we_o == (mc_kind_i == 3'h2))
		else $error("memory controls wrong");
	a_mem_hold: assert property (tk_mem |=>
		(mem_en_o && $stable(mem_addr_o) && $stable(mem_we_o)) until mc_done_o)
		else $error("memory outputs moved in wait");
	a_mem_len: assert property (tk_mem |=> !mc_done_o ##[1:60] mc_done_o)
		else $error("memory cycle length wrong");
	a_sio_setup: assert property (tk_sio |-> bit_addr_o == mc_addr_i &&
		(!tk_out || serial_io_output_o == mc_wdata_i[0]))
		else $error("bit address or bit late");
	a_strobe_at: assert property (tk_out |=> serial_io_strobe_o ##1 !serial_io_strobe_o)
		else $error("strobe not one pulse");
	a_bit_time: assert property (bit_valid_o |-> $past(mc_done_o, 3))
		else $error("input bit timing wrong");
endmodule

bind mcs_sequencer mcs_seq_checker #(.AW(AW), .DW(DW)) chk_u (.clk_i(clk_i),
	.resetn_i(resetn_i), .mc_kind_i(mc_kind_i), .mc_addr_i(mc_addr_i),
	.mc_wdata_i(mc_wdata_i), .mem_addr_o(mem_addr_o), .mem_en_o(mem_en_o),
	.mem_we_o(mem_we_o), .bit_addr_o(bit_addr_o), .serial_io_output_o(serial_io_output_o),
	.serial_io_strobe_o(serial_io_strobe_o), .bit_valid_o(bit_valid_o),
	.mc_take_o(mc_take_o), .mc_done_o(mc_done_o));
`default_nettype wire

// ==== bench/mcs_bus_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// -----------------------------
// Memory and bit device model
// -----------------------------
module mcs_bus_model #(
	parameter logic [15:0] PAT = 16'ha5c3,
	parameter WAITS = 6
) (
	// Clock and stall control
	input wire logic clk_i,
	input wire logic stall_i,
	// Bus from the sequencer
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic en_i,
	input wire logic we_i,
	input wire logic [15:0] bit_addr_i,
	// Answers
	output logic ready_o,
	output logic [15:0] rdata_o,
	output logic sin_o
);
	logic [15:0] mem_q [0:15];
	logic [15:0] last_q = '0;
	logic [3:0] cnt_q = '0;
	initial for (int i = 0; i < 16; i++) mem_q[i] = 16'(i);
	// Store writes, count stall clocks
	always @(posedge clk_i) begin
		if (en_i && we_i) begin
			mem_q[addr_i[3:0]] <= wdata_i;
		end
		last_q <= rdata_o;
		cnt_q <= stall_i ? cnt_q + 4'(cnt_q != 4'hf) : 4'h0;
	end
	// Unselected data flips every clock
	assign rdata_o = en_i ? mem_q[addr_i[3:0]] : ~last_q;
	// Ready low early in a stall
	assign ready_o = !(stall_i && cnt_q < WAITS);
	// Input bit stands long before sampling
	assign sin_o = PAT[bit_addr_i[3:0]];
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic istart = 1'b0, iend = 1'b0, req = 1'b0, ext = 1'b0, stall = 1'b0, dst = 1'b0;
	logic [15:0] op = '0, addr = '0, wdata = '0;
	logic [2:0] kind = '0;
	logic [1:0] ts = '0, td = '0;
	logic [3:0] nib = 4'h5;
	logic ready, sin, mem_en, mem_we, sout, sbit, bvalid, take, done, trap, xexec;
	logic [15:0] rdata, mem_addr, mem_wdata, rdata_o, bit_addr;
	logic [3:0] phase, cmem;
	logic [7:0] cclk;
	int num_errors = 0, checked = 0, cycles = 0, n, k;

	initial forever #50 clk_i = ~clk_i;

	mcs_sequencer dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .instr_start_i(istart),
		.instr_end_i(iend), .opcode_i(op), .base_clk_i(8'h0c), .base_mem_i(4'h4),
		.ts_i(ts), .s_reg_zero_i(1'b0), .td_i(td), .d_reg_zero_i(1'b0), .use_dst_i(dst),
		.workspace_reg_zero_i(nib), .mc_req_i(req), .mc_kind_i(kind), .mc_addr_i(addr),
		.mc_wdata_i(wdata), .ready_i(ready), .serial_io_input_i(sin),
		.ext_instr_present_i(ext), .mem_rdata_i(rdata), .mem_addr_o(mem_addr),
		.mem_wdata_o(mem_wdata), .mem_en_o(mem_en), .mem_we_o(mem_we), .rdata_o(rdata_o),
		.bit_addr_o(bit_addr), .serial_io_output_o(sout), .serial_io_strobe_o(),
		.serial_io_bit_o(sbit), .bit_valid_o(bvalid), .mc_take_o(take), .mc_done_o(done),
		.phase_o(phase), .cost_clk_o(cclk), .cost_mem_o(cmem), .trap_o(trap),
		.ext_exec_o(xexec));

	mcs_bus_model far_u (.clk_i(clk_i), .stall_i(stall), .addr_i(mem_addr),
		.wdata_i(mem_wdata), .en_i(mem_en), .we_i(mem_we), .bit_addr_i(bit_addr),
		.ready_o(ready), .rdata_o(rdata), .sin_o(sin));

	// --------------
	// Shared tasks
	// --------------
	task automatic results();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic ok);
		checked++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t check %0d mismatch", $time, checked);
		end
	endtask

	// One machine cycle; n is clocks from take to done
	task automatic mc(input logic [2:0] kd, input logic [15:0] a, input logic [15:0] d);
		kind <= kd;
		addr <= a;
		wdata <= d;
		req <= 1'b1;
		n = 0;
		do @(posedge clk_i); while (take !== 1'b1 && ++n < 50);
		req <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (done !== 1'b1 && n < 60);
	endtask

	// One instruction through its phases, the destination phase only when d is nonzero
	task automatic instr(input logic [15:0] o, input logic [1:0] s, input logic [1:0] d,
		input logic x, input logic [7:0] ec, input logic [3:0] em, input logic et,
		input logic ee, input int nd);
		op <= o;
		ts <= s;
		td <= d;
		dst <= (d != 2'h0);
		ext <= x;
		repeat (6) @(posedge clk_i);
		istart <= 1'b1;
		n = 0;
		k = 0;
		do begin
			@(posedge clk_i);
			istart <= 1'b0;
			k += int'(done === 1'b1);
			n++;
		end while (phase !== 4'h8 && n < 200);
		check(cclk === ec && cmem === em && trap === et && xexec === ee);
		// Last derivation cycle may end after the phase switch
		repeat (4) begin
			@(posedge clk_i);
			k += int'(done === 1'b1);
		end
		check(k == nd);
		iend <= 1'b1;
		@(posedge clk_i);
		iend <= 1'b0;
		repeat (3) @(posedge clk_i);
		check(phase === 4'h1);
	endtask

	// -----------
	// Scenarios
	// -----------
	task automatic t_mem();
		mc(3'h2, 16'h0003, 16'h1234);
		check(n == 2);
		mc(3'h1, 16'h0003, 16'h0000);
		check(n == 2 && rdata_o === 16'h1234);
	endtask

	task automatic t_alu();
		logic [15:0] a;
		a = mem_addr;
		mc(3'h0, 16'h0077, 16'h0000);
		check(n == 2 && mem_addr === a && mem_en === 1'b0);
	endtask

	task automatic t_wait();
		stall <= 1'b1;
		repeat (3) @(posedge clk_i);
		mc(3'h1, 16'h0003, 16'h0000);
		check(n > 2 && rdata_o === 16'h1234);
		stall <= 1'b0;
		repeat (12) @(posedge clk_i);
		stall <= 1'b1;
		repeat (3) @(posedge clk_i);
		mc(3'h4, 16'h0009, 16'h0001);
		check(n > 2);
		stall <= 1'b0;
		repeat (12) @(posedge clk_i);
	endtask

	task automatic t_sio();
		mc(3'h4, 16'h0005, 16'h0001);
		check(n == 2 && sout === 1'b1);
		mc(3'h4, 16'h0007, 16'h0000);
		check(bit_addr === 16'h0007 && sout === 1'b0);
		// Pattern bit 2 is low, bit 7 high: the pin must follow the new address
		mc(3'h3, 16'h0002, 16'h0000);
		k = 0;
		while (bvalid !== 1'b1 && k < 8) begin
			@(posedge clk_i);
			k++;
		end
		check(sbit === 1'b0 && n == 2);
		mc(3'h3, 16'h0007, 16'h0000);
		k = 0;
		while (bvalid !== 1'b1 && k < 8) begin
			@(posedge clk_i);
			k++;
		end
		check(sbit === 1'b1 && n == 2);
	endtask

	task automatic t_cost();
		instr(16'h0c00, 2'h0, 2'h0, 1'b0, 8'h18, 4'h6, 1'b1, 1'b0, 0);
		instr(16'h0c00, 2'h0, 2'h0, 1'b1, 8'h00, 4'h0, 1'b0, 1'b1, 0);
		instr(16'h0800, 2'h0, 2'h0, 1'b0, 8'h1e, 4'h4, 1'b0, 1'b0, 0);
		instr(16'h0830, 2'h0, 2'h0, 1'b0, 8'h12, 4'h3, 1'b0, 1'b0, 0);
		instr(16'h0480, 2'h1, 2'h0, 1'b0, 8'h08, 4'h2, 1'b0, 1'b0, 2);
		instr(16'ha000, 2'h3, 2'h1, 1'b0, 8'h16, 4'h7, 1'b0, 1'b0, 5);
		instr(16'ha000, 2'h0, 2'h0, 1'b0, 8'h0c, 4'h4, 1'b0, 1'b0, 0);
		instr(16'ha000, 2'h2, 2'h0, 1'b0, 8'h12, 4'h6, 1'b0, 1'b0, 3);
	endtask

	// ------------------
	// Main and timeout
	// ------------------
	initial begin
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		t_mem();
		t_alu();
		t_wait();
		t_sio();
		t_cost();
		results();
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end
endmodule
`default_nettype wire
